/* hw/rcrb_pkg.sv */
// constants and register map of the regulator control register bank
package rcrb_pkg;
   // register indices; the byte address on the bus is four times the index
   localparam logic [7:0] IDX_LDO_A_VSEL = 8'h80;
   localparam logic [7:0] IDX_LDO_A_CTRL = 8'h81;
   localparam logic [7:0] IDX_LDO_B_VSEL = 8'h90;
   localparam logic [7:0] IDX_LDO_B_CTRL = 8'h91;
   localparam logic [7:0] IDX_LDO_C_VSEL = 8'hA0;
   localparam logic [7:0] IDX_LDO_C_CTRL = 8'hA1;
   localparam logic [7:0] IDX_KEEPALIVE = 8'hB1;
   localparam logic [7:0] IDX_BUTTON_WD = 8'hC0;
   localparam logic [7:0] IDX_IRQ_SOURCE = 8'hC1;
   localparam logic [7:0] IDX_BUTTON_STAT = 8'hC2;
   localparam logic [7:0] IDX_CTRL_STEP = 8'h01;
   // field positions
   localparam int VCODE_MSB = 5;
   localparam int CTRL_ENABLE_BIT = 7;
   localparam int CTRL_DISCHARGE_BIT = 2;
   localparam int CTRL_FAULT_IRQ_BIT = 1;
   localparam int CTRL_PGOOD_BIT = 0;
   localparam int BTN_PRESS_IRQ_BIT = 7;
   localparam int BTN_RELEASE_IRQ_BIT = 6;
   localparam int BTN_WD_SRST_BIT = 1;
   localparam int STAT_PRESS_BIT = 7;
   localparam int STAT_RELEASE_BIT = 6;
   localparam int STAT_PIN_BIT = 5;
   // values after reset
   localparam logic [5:0] RST_VCODE = 6'h00;
   localparam logic RST_ENABLE = 1'b0;
   localparam logic RST_DISCHARGE = 1'b0;
   localparam logic RST_FAULT_IRQ = 1'b0;
   localparam logic RST_KEEPALIVE = 1'b1;
   localparam logic RST_BTN_IRQ = 1'b0;
   localparam logic RST_WD_SRST = 1'b0;
   localparam logic RST_BUTTON_LEVEL = 1'b1; // button pin idles high
   localparam logic [7:0] RST_IRQ_SOURCE = 8'hFF;
   localparam logic [7:0] IRQ_SOURCE_EMPTY = 8'hFF;
   // number of linear regulators in the bank
   localparam int LDO_COUNT = 3;
   // bus answer
   localparam logic [31:0] RDATA_IDLE = 32'h0000_0000;
endpackage : rcrb_pkg

/* hw/rcrb_bus_if.sv */
// internal register write bus from the bus slave to the regulator channels
`timescale 1ns/1ps
interface rcrb_bus_if;
   logic wr;
   logic [7:0] idx;
   logic [7:0] wdata;
   modport source (output wr, output idx, output wdata);
   modport sink (input wr, input idx, input wdata);
endinterface : rcrb_bus_if

/* hw/rcrb_sync2.sv */
// two flip-flop synchroniser for level inputs from outside the clock domain
`timescale 1ns/1ps
module rcrb_sync2 #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // asynchronous levels in, synchronised levels out
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_q
);
   logic [W-1:0] meta_q;

   // first stage read only by the second stage
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_q <= RST_VAL;
         sync_q <= RST_VAL;
      end else begin
         meta_q <= async_in;
         sync_q <= meta_q;
      end
   end
endmodule : rcrb_sync2

/* hw/rcrb_ldo_channel.sv */
// voltage and control fields of one linear regulator
`timescale 1ns/1ps
module rcrb_ldo_channel import rcrb_pkg::*; #(
   parameter logic [7:0] BASE_IDX = IDX_LDO_A_VSEL
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // register writes
   rcrb_bus_if.sink bus,
   // stored fields
   output logic [5:0] voltage_code_q,
   output logic enable_q,
   output logic discharge_sel_q,
   output logic fault_irq_en_q
);
   logic [7:0] ctrl_idx;

   assign ctrl_idx = BASE_IDX + IDX_CTRL_STEP;

   // six-bit voltage code, upper bits dropped
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         voltage_code_q <= RST_VCODE;
      end else if (bus.wr && bus.idx == BASE_IDX) begin
         voltage_code_q <= bus.wdata[VCODE_MSB:0]; // RL1 RL12
      end
   end

   // enable, discharge and fault interrupt enable; power-good is not stored
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         enable_q <= RST_ENABLE;
         discharge_sel_q <= RST_DISCHARGE;
         fault_irq_en_q <= RST_FAULT_IRQ;
      end else if (bus.wr && bus.idx == ctrl_idx) begin
         enable_q <= bus.wdata[CTRL_ENABLE_BIT]; // RL2
         discharge_sel_q <= bus.wdata[CTRL_DISCHARGE_BIT]; // RL3
         fault_irq_en_q <= bus.wdata[CTRL_FAULT_IRQ_BIT]; // RL4
      end
   end
endmodule : rcrb_ldo_channel

/* hw/rcrb_top.sv */
// regulator control register bank with apb slave
//
// Behaviour
// (RL1) each regulator voltage register keeps a read/write six-bit voltage code in bits 5:0.
// (RL2) bit 7 of each regulator control register, keep-alive included, switches it on or off.
// (RL3) bit 2 of a linear regulator control register discharges its output while it is off.
// (RL4) bit 1 of a linear regulator control register lets its faults raise an interrupt.
// (RL5) bit 0 of a linear regulator control register reads its power-good state, read only.
// (RL6) bit 7 of the button control byte raises an interrupt when the button is pressed.
// (RL7) bit 6 of the button control byte raises an interrupt when the button is released.
// (RL8) bit 1 of the button control byte lets watchdog expiry start a soft reset.
// (RL9) entering sleep clears the watchdog soft-reset enable bit.
// (RL10) a read-only status bit shows one once the press interrupt has fired.
// (RL11) the interrupt source register holds the raising block, resets to ones, and reads to ones.
// (RL12) reserved bits read zero and writes to them change nothing.
//
// Local design decision: the APB register port.
`timescale 1ns/1ps
module rcrb_top import rcrb_pkg::*; (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [9:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // regulator monitors from the analog side
   input wire logic [2:0] ldo_power_good,
   input wire logic [2:0] ldo_fault,
   // push button pin, low while pressed
   input wire logic push_button_input_n,
   // sequencer events on this clock
   input wire logic sleep_entry,
   input wire logic watchdog_expired,
   // regulator controls
   output logic [17:0] ldo_voltage_code,
   output logic [2:0] ldo_enable,
   output logic [2:0] ldo_discharge_on,
   output logic keepalive_enable,
   // system events
   output logic irq,
   output logic soft_reset_start
);
   ////////////////////////////////////////////////////////////////////////////////
   // declarations
   rcrb_bus_if wbus ();
   logic pready_q;
   logic pslverr_q;
   logic [31:0] prdata_q;
   logic access;
   logic setup_answer;
   logic done;
   logic rd_done;
   logic [7:0] idx;
   logic [7:0] rdata;
   logic [2:0] pg_sync;
   logic [2:0] fault_sync;
   logic [2:0] fault_prev_q;
   logic [2:0] fault_evt;
   logic btn_sync_n;
   logic btn_prev_n_q;
   logic press_evt;
   logic release_evt;
   logic [5:0] vcode [LDO_COUNT];
   logic [2:0] en_w;
   logic [2:0] dis_w;
   logic [2:0] fen_w;
   logic [2:0] discharge_q;
   logic keepalive_q;
   logic press_irq_en_q;
   logic release_irq_en_q;
   logic wd_srst_en_q;
   logic press_flag_q;
   logic release_flag_q;
   logic [7:0] src_q;
   logic [7:0] src_d;
   logic any_evt;
   logic irq_q;
   logic srst_q;

   // true for every index that holds a register
   function automatic logic rcrb_mapped(input logic [7:0] i);
      rcrb_mapped = (i == IDX_LDO_A_VSEL) || (i == IDX_LDO_A_CTRL) ||
                    (i == IDX_LDO_B_VSEL) || (i == IDX_LDO_B_CTRL) ||
                    (i == IDX_LDO_C_VSEL) || (i == IDX_LDO_C_CTRL) ||
                    (i == IDX_KEEPALIVE) || (i == IDX_BUTTON_WD) ||
                    (i == IDX_IRQ_SOURCE) || (i == IDX_BUTTON_STAT);
   endfunction : rcrb_mapped

   ////////////////////////////////////////////////////////////////////////////////
   // apb handshake: one wait state, writes and read-clear side effects act on the completing edge
   assign idx = paddr[9:2];
   assign access = psel && penable;
   assign setup_answer = access && !pready_q;
   assign done = access && pready_q;
   assign rd_done = done && !pwrite && rcrb_mapped(idx) && (paddr[1:0] == 2'b00);

   // ready, error and read data registered in the first access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= RDATA_IDLE;
      end else begin
         pready_q <= setup_answer;
         pslverr_q <= setup_answer && !(rcrb_mapped(idx) && paddr[1:0] == 2'b00);
         prdata_q <= (setup_answer && !pwrite) ? {24'h00_0000, rdata} : RDATA_IDLE;
      end
   end

   // internal write strobe for the channels
   assign wbus.wr = done && pwrite && (paddr[1:0] == 2'b00);
   assign wbus.idx = idx;
   assign wbus.wdata = pwdata[7:0];

   ////////////////////////////////////////////////////////////////////////////////
   // input synchronisers and edge detection
   // button stage starts at its released level, so no false edge follows reset
   rcrb_sync2 #(.W(7), .RST_VAL({RST_BUTTON_LEVEL, 6'h00})) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .async_in({push_button_input_n, ldo_fault, ldo_power_good}),
      .sync_q({btn_sync_n, fault_sync, pg_sync})
   );

   // previous synchronised levels for edge detection
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fault_prev_q <= 3'h0;
         btn_prev_n_q <= 1'b1;
      end else begin
         fault_prev_q <= fault_sync;
         btn_prev_n_q <= btn_sync_n;
      end
   end

   // interrupt events, each gated by its enable
   assign fault_evt = fault_sync & ~fault_prev_q & fen_w; // RL4
   assign press_evt = btn_prev_n_q && !btn_sync_n && press_irq_en_q; // RL6
   assign release_evt = !btn_prev_n_q && btn_sync_n && release_irq_en_q; // RL7
   assign any_evt = (|fault_evt) || press_evt || release_evt;

   ////////////////////////////////////////////////////////////////////////////////
   // linear regulator channels
   localparam logic [7:0] CH_BASE [LDO_COUNT] = '{IDX_LDO_A_VSEL, IDX_LDO_B_VSEL, IDX_LDO_C_VSEL};

   generate
      for (genvar g = 0; g < LDO_COUNT; g++) begin : g_ldo
         rcrb_ldo_channel #(.BASE_IDX(CH_BASE[g])) u_ch (
            .pclk(pclk),
            .presetn(presetn),
            .bus(wbus.sink),
            .voltage_code_q(vcode[g]),
            .enable_q(en_w[g]),
            .discharge_sel_q(dis_w[g]),
            .fault_irq_en_q(fen_w[g])
         );
         assign ldo_voltage_code[6*g+5:6*g] = vcode[g]; // RL1
      end
   endgenerate

   // discharge switch closed only while the regulator is off
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         discharge_q <= 3'h0;
      end else begin
         discharge_q <= dis_w & ~en_w; // RL3
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // keep-alive regulator enable
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         keepalive_q <= RST_KEEPALIVE;
      end else if (wbus.wr && idx == IDX_KEEPALIVE) begin
         keepalive_q <= pwdata[CTRL_ENABLE_BIT]; // RL2
      end
   end

   // button interrupt enables
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         press_irq_en_q <= RST_BTN_IRQ;
         release_irq_en_q <= RST_BTN_IRQ;
      end else if (wbus.wr && idx == IDX_BUTTON_WD) begin
         press_irq_en_q <= pwdata[BTN_PRESS_IRQ_BIT]; // RL6
         release_irq_en_q <= pwdata[BTN_RELEASE_IRQ_BIT]; // RL7
      end
   end

   // watchdog soft-reset enable, sleep entry beats a write
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wd_srst_en_q <= RST_WD_SRST;
      end else if (sleep_entry) begin
         wd_srst_en_q <= 1'b0; // RL9
      end else if (wbus.wr && idx == IDX_BUTTON_WD) begin
         wd_srst_en_q <= pwdata[BTN_WD_SRST_BIT]; // RL8
      end
   end

   // soft reset start pulse on watchdog expiry
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         srst_q <= 1'b0;
      end else begin
         srst_q <= wd_srst_en_q && watchdog_expired; // RL8
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // button status flags, cleared by reading the status register, set wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         press_flag_q <= 1'b0;
         release_flag_q <= 1'b0;
      end else begin
         press_flag_q <= press_evt || (press_flag_q && !(rd_done && idx == IDX_BUTTON_STAT)); // RL10
         release_flag_q <= release_evt ||
                           (release_flag_q && !(rd_done && idx == IDX_BUTTON_STAT));
      end
   end

   // source address: first event into an empty register, read refills ones
   always_comb begin
      src_d = src_q;
      if (rd_done && idx == IDX_IRQ_SOURCE) begin
         src_d = IRQ_SOURCE_EMPTY; // RL11
      end
      if (src_d == IRQ_SOURCE_EMPTY) begin
         if (fault_evt[0]) begin
            src_d = IDX_LDO_A_VSEL;
         end else if (fault_evt[1]) begin
            src_d = IDX_LDO_B_VSEL;
         end else if (fault_evt[2]) begin
            src_d = IDX_LDO_C_VSEL;
         end else if (press_evt || release_evt) begin
            src_d = IDX_BUTTON_WD;
         end
      end
   end

   // interrupt line, held until the source register is read
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         src_q <= RST_IRQ_SOURCE;
         irq_q <= 1'b0;
      end else begin
         src_q <= src_d; // RL11
         irq_q <= any_evt || (irq_q && !(rd_done && idx == IDX_IRQ_SOURCE));
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // read data mux, reserved bits zero
   always_comb begin
      rdata = 8'h00; // RL12
      if (idx == IDX_LDO_A_VSEL) begin
         rdata = {2'b00, vcode[0]};
      end else if (idx == IDX_LDO_A_CTRL) begin
         rdata = {en_w[0], 4'h0, dis_w[0], fen_w[0], pg_sync[0]}; // RL5
      end else if (idx == IDX_LDO_B_VSEL) begin
         rdata = {2'b00, vcode[1]};
      end else if (idx == IDX_LDO_B_CTRL) begin
         rdata = {en_w[1], 4'h0, dis_w[1], fen_w[1], pg_sync[1]}; // RL5
      end else if (idx == IDX_LDO_C_VSEL) begin
         rdata = {2'b00, vcode[2]};
      end else if (idx == IDX_LDO_C_CTRL) begin
         rdata = {en_w[2], 4'h0, dis_w[2], fen_w[2], pg_sync[2]}; // RL5
      end else if (idx == IDX_KEEPALIVE) begin
         rdata = {keepalive_q, 7'h00};
      end else if (idx == IDX_BUTTON_WD) begin
         rdata = {press_irq_en_q, release_irq_en_q, 4'h0, wd_srst_en_q, 1'b0};
      end else if (idx == IDX_IRQ_SOURCE) begin
         rdata = src_q;
      end else if (idx == IDX_BUTTON_STAT) begin
         rdata = {press_flag_q, release_flag_q, !btn_sync_n, 5'h00}; // RL10
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // outputs
   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign ldo_enable = en_w;
   assign ldo_discharge_on = discharge_q;
   assign keepalive_enable = keepalive_q;
   assign irq = irq_q;
   assign soft_reset_start = srst_q;

   ////////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   chk_vcode_write: assert property ( // RL1
      wbus.wr && idx == IDX_LDO_A_VSEL |=> ldo_voltage_code[5:0] == $past(pwdata[5:0]))
      else $error("voltage code not stored");
   chk_keepalive_write: assert property ( // RL2
      wbus.wr && idx == IDX_KEEPALIVE |=> keepalive_enable == $past(pwdata[7]))
      else $error("keep-alive enable not stored");
   chk_discharge_off: assert property ( // RL3
      ldo_discharge_on[0] |-> $past(dis_w[0]) && !$past(en_w[0]))
      else $error("discharge while regulator on");
   chk_fault_irq: assert property ( // RL4
      fault_evt[1] |=> irq ##0 src_q != IRQ_SOURCE_EMPTY)
      else $error("enabled fault raised no interrupt");
   chk_pgood_read: assert property ( // RL5
      setup_answer && !pwrite && idx == IDX_LDO_B_CTRL |=> prdata[0] == $past(pg_sync[1]))
      else $error("power-good bit wrong on read");
   chk_press_flag: assert property ( // RL6
      press_evt |=> press_flag_q && irq)
      else $error("press event lost");
   chk_release_flag: assert property ( // RL7
      release_evt |=> release_flag_q && irq)
      else $error("release event lost");
   chk_stat_clear: assert property ( // RL10
      rd_done && idx == IDX_BUTTON_STAT && !press_evt |=> !press_flag_q)
      else $error("press flag not cleared by status read");
   chk_ctrl_write: assert property ( // RL2
      wbus.wr && idx == IDX_LDO_C_CTRL |=> ldo_enable[2] == $past(pwdata[7]))
      else $error("regulator enable not stored");
   chk_wd_srst: assert property ( // RL8
      wd_srst_en_q && watchdog_expired |=> soft_reset_start ##1 !soft_reset_start || $past(watchdog_expired))
      else $error("soft reset not started");
   chk_sleep_clear: assert property ( // RL9
      sleep_entry |=> !wd_srst_en_q)
      else $error("watchdog enable survived sleep");
   chk_src_refill: assert property ( // RL11
      rd_done && idx == IDX_IRQ_SOURCE && !any_evt |=> src_q == IRQ_SOURCE_EMPTY)
      else $error("source register not refilled");
   chk_reserved_zero: assert property ( // RL12
      pready && !pwrite && $past(idx) == IDX_LDO_C_CTRL |-> prdata[31:3] == 29'h0 ||
      prdata[31:8] == 24'h0 && prdata[6:3] == 4'h0)
      else $error("reserved bits not zero");
   chk_ready_pulse: assert property (
      pready |=> !pready)
      else $error("ready held longer than one cycle");
endmodule : rcrb_top

/* sim/tb_rcrb_top.sv */
// self-checking testbench of the regulator control register bank
`timescale 1ns/1ps
module tb_rcrb_top import rcrb_pkg::*;;
   logic pclk, presetn, psel, penable, pwrite;
   logic [9:0] paddr;
   logic [31:0] pwdata, prdata, seed, rdv;
   logic pready, pslverr, push_button_input_n, sleep_entry, watchdog_expired;
   logic irq, soft_reset_start, keepalive_enable, errv;
   logic [2:0] ldo_power_good, ldo_fault, ldo_enable, ldo_discharge_on;
   logic [17:0] ldo_voltage_code;
   int err_total, cmp_count, cycles;

   rcrb_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .ldo_power_good(ldo_power_good), .ldo_fault(ldo_fault),
      .push_button_input_n(push_button_input_n), .sleep_entry(sleep_entry),
      .watchdog_expired(watchdog_expired), .ldo_voltage_code(ldo_voltage_code),
      .ldo_enable(ldo_enable), .ldo_discharge_on(ldo_discharge_on),
      .keepalive_enable(keepalive_enable), .irq(irq), .soft_reset_start(soft_reset_start));

   ////////////////////////////////////////////////////////////////////////////////
   // clock and hang guard
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end

   // a hang counts as a mismatch
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 5000) begin
         err_total++;
         wrap_up();
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // helpers
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd

   // control byte as read back: enable, discharge, fault enable, power good
   function automatic logic [31:0] exp_ctrl(logic [31:0] d, logic pg);
      return {24'h0, d[7], 4'h0, d[2], d[1], pg};
   endfunction : exp_ctrl

   task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         $display("unexpected %s expected %h seen %h", nm, e, g);
         err_total++;
      end
   endtask : chk

   // one apb transfer; request held until pready is sampled high
   task automatic apb(logic wr, logic [9:0] addr, logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= addr;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rdv = prdata;
      errv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rd(logic [7:0] idx, logic [31:0] e, string nm);
      apb(1'b0, {idx, 2'b00}, rnd());
      chk(nm, e, rdv);
      chk("read error flag", 32'h0, 32'(errv));
   endtask : rd

   task automatic wr(logic [7:0] idx, logic [31:0] d);
      apb(1'b1, {idx, 2'b00}, d);
      chk("write error flag", 32'h0, 32'(errv));
   endtask : wr

   task automatic idle(int n);
      repeat (n) @(posedge pclk);
      #1;
   endtask : idle

   // one watchdog expiry pulse and the soft reset answer
   task automatic pulse_wd(logic e);
      @(posedge pclk);
      watchdog_expired <= 1'b1;
      @(posedge pclk);
      watchdog_expired <= 1'b0;
      #1;
      chk("soft reset pulse", 32'(e), 32'(soft_reset_start));
      idle(1);
      chk("soft reset end", 32'h0, 32'(soft_reset_start));
   endtask : pulse_wd

   task automatic wrap_up();
      if (err_total == 0 && cmp_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : wrap_up

   ////////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      logic [31:0] d, r;
      logic [7:0] vi, ci;
      int ch;
      seed = 32'h53;
      {presetn, psel, penable, pwrite, sleep_entry, watchdog_expired} = 6'h00;
      paddr = 10'h000;
      pwdata = 32'h0;
      ldo_power_good = 3'h0;
      ldo_fault = 3'h0;
      push_button_input_n = 1'b1;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      // reset values
      for (int i = 0; i < 3; i++) begin
         rd(IDX_LDO_A_VSEL + 8'(16 * i), 32'h0, "vcode reset");
         rd(IDX_LDO_A_CTRL + 8'(16 * i), 32'h0, "ctrl reset");
      end
      rd(IDX_KEEPALIVE, 32'h80, "keepalive reset");
      rd(IDX_BUTTON_WD, 32'h0, "button ctrl reset");
      rd(IDX_IRQ_SOURCE, 32'hFF, "source reset");
      rd(IDX_BUTTON_STAT, 32'h0, "button stat reset");
      chk("keepalive pin", 32'h1, 32'(keepalive_enable));
      // random fields, all ones and all zeros first
      for (int i = 0; i < 24; i++) begin
         r = rnd();
         ch = int'(r[9:8]) % 3;
         vi = IDX_LDO_A_VSEL + 8'(16 * ch);
         ci = IDX_LDO_A_CTRL + 8'(16 * ch);
         ldo_power_good <= r[2:0];
         d = (i == 0) ? 32'hFFFF_FFFF : (i == 1) ? 32'h0 : rnd();
         wr(vi, d);
         rd(vi, {26'h0, d[5:0]}, "vcode");
         chk("vcode pin", 32'(d[5:0]), 32'(ldo_voltage_code[6 * ch +: 6]));
         d = (i == 0) ? 32'hFFFF_FFFF : (i == 1) ? 32'h0 : rnd();
         wr(ci, d);
         rd(ci, exp_ctrl(d, r[ch]), "ctrl");
         chk("enable pin", 32'(d[7]), 32'(ldo_enable[ch]));
         chk("discharge pin", 32'(d[2] & ~d[7]), 32'(ldo_discharge_on[ch]));
      end
      // keep-alive regulator off and on
      for (int k = 0; k < 2; k++) begin
         wr(IDX_KEEPALIVE, k ? 32'hFFFF_FFFF : 32'h0);
         rd(IDX_KEEPALIVE, k ? 32'h80 : 32'h0, "keepalive");
         chk("keepalive pin", 32'(k), 32'(keepalive_enable));
      end
      // button control, read-only source, unmapped and misaligned access
      wr(IDX_BUTTON_WD, 32'hFFFF_FFFF);
      rd(IDX_BUTTON_WD, 32'hC2, "button ctrl");
      wr(IDX_IRQ_SOURCE, 32'h0);
      rd(IDX_IRQ_SOURCE, 32'hFF, "source read only");
      wr(IDX_LDO_A_VSEL, 32'h15);
      apb(1'b0, {8'h82, 2'b00}, 32'h0);
      chk("unmapped error", 32'h1, 32'(errv));
      chk("unmapped data", 32'h0, rdv);
      apb(1'b1, {IDX_LDO_A_VSEL, 2'b01}, 32'h3F);
      chk("misaligned error", 32'h1, 32'(errv));
      rd(IDX_LDO_A_VSEL, 32'h15, "vcode kept");
      // watchdog soft reset, then sleep clears its enable
      pulse_wd(1'b1);
      @(posedge pclk);
      sleep_entry <= 1'b1;
      @(posedge pclk);
      sleep_entry <= 1'b0;
      rd(IDX_BUTTON_WD, 32'hC0, "enable after sleep");
      pulse_wd(1'b0);
      // fault interrupts, only ldo_b enabled
      wr(IDX_LDO_A_CTRL, 32'h0);
      wr(IDX_LDO_B_CTRL, 32'h2);
      wr(IDX_LDO_C_CTRL, 32'h0);
      ldo_fault <= 3'b101;
      idle(8);
      chk("masked fault irq", 32'h0, 32'(irq));
      @(posedge pclk);
      ldo_fault <= 3'b111;
      idle(8);
      chk("fault irq", 32'h1, 32'(irq));
      rd(IDX_IRQ_SOURCE, 32'h90, "fault source");
      idle(1);
      chk("irq after source read", 32'h0, 32'(irq));
      rd(IDX_IRQ_SOURCE, 32'hFF, "source refilled");
      ldo_fault <= 3'b000;
      // button press and release interrupts
      push_button_input_n <= 1'b0;
      idle(8);
      chk("press irq", 32'h1, 32'(irq));
      rd(IDX_BUTTON_STAT, 32'hA0, "press flag");
      rd(IDX_IRQ_SOURCE, 32'hC0, "press source");
      rd(IDX_BUTTON_STAT, 32'h20, "press flag cleared");
      push_button_input_n <= 1'b1;
      idle(8);
      chk("release irq", 32'h1, 32'(irq));
      rd(IDX_BUTTON_STAT, 32'h40, "release flag");
      rd(IDX_IRQ_SOURCE, 32'hC0, "release source");
      // press with its interrupt disabled
      wr(IDX_BUTTON_WD, 32'h0);
      push_button_input_n <= 1'b0;
      idle(8);
      chk("masked press irq", 32'h0, 32'(irq));
      wrap_up();
   end
endmodule : tb_rcrb_top
